// File: hdl/utx_ep_ctrl.sv
// transmit endpoint control/status logic with axi4-lite register slave
`timescale 1ns/1ps
module utx_ep_ctrl #(
	parameter int ADDR_W = 8
) (
	input  wire logic              core_clk,
	input  wire logic              rst_b,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              host_role_pin,
	input  wire logic              in_token,
	input  wire logic              pkt_sent,
	input  wire logic              stall_sent_evt,
	input  wire logic              stall_rcvd_evt,
	input  wire logic              nak_rcvd,
	input  wire logic              no_handshake,
	input  wire logic              iso_split_short,
	output logic                   tx_pkt_pending,
	output logic                   send_stall_out,
	output logic                   setup_token_out,
	output logic                   data_toggle,
	output logic                   ep_halted,
	output logic                   fifo_flush,
	output logic                   dma_abort,
	output logic                   irq
);
	import utx_pkg::*;

	if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
		$error("utx_ep_ctrl: ADDR_W must lie between 8 and 32");
	end

	typedef struct packed {
		logic              aw_got;
		logic [ADDR_W-1:0] awaddr;
		logic              w_got;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic              tpr;
		logic              stall_setup;
		logic              flag_incp_nak;
		logic              flag_stall;
		logic              flag_undr_err;
		logic              toggle;
		logic [1:0]        pkt_cnt;
		logic [NAK_W-1:0]  nak_cnt;
		logic [1:0]        retry_cnt;
		logic              halted;
		logic [IRQ_W-1:0]  irq_sts;
		logic [IRQ_W-1:0]  irq_mask;
		logic              cfg_iso;
		logic              cfg_double;
		logic [NAK_W-1:0]  nak_limit;
		logic              flush_p;
		logic              dma_abort_p;
		logic              irq;
		logic              send_stall;
		logic              setup_tok;
		logic              pending;
	} utx_state_type;

	utx_state_type s_r, s_nxt;
	logic          host_q;
	logic          do_wr;

	// role pin crosses in from outside the clock domain
	utx_sync3 u_role_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.pin_in   (host_role_pin),
		.level_q  (host_q)
	);

	// read view of the shared registers; bits 23, 21, 20, 18 change meaning with role
	function automatic logic [31:0] read_reg(input utx_state_type s, input logic host,
	                                         input logic [ADDR_W-1:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a[7:0])
			OFS_EP_CSR: begin
				v[BIT_TX_PACKET_READY] = s.tpr;
				v[BIT_FIFO_NOT_EMPTY]  = (s.pkt_cnt != 2'h0);                 // see RULE14
				v[BIT_UNDERRUN_ERROR]  = s.flag_undr_err;                     // see RULE17
				v[BIT_STALL_SETUP]     = s.stall_setup;
				v[BIT_STALL_FLAG]      = s.flag_stall;
				v[BIT_INCOMP_NAK]      = s.flag_incp_nak & (host | s.cfg_iso); // see RULE2
			end
			OFS_IRQ_STS:  v[IRQ_W-1:0] = s.irq_sts;
			OFS_IRQ_MASK: v[IRQ_W-1:0] = s.irq_mask;
			OFS_CFG: begin
				v[CFG_ISO]    = s.cfg_iso;
				v[CFG_DOUBLE] = s.cfg_double;
				v[CFG_NAK_LSB +: NAK_W] = s.nak_limit;
			end
			OFS_STATE: begin
				v[0]   = host;
				v[1]   = s.toggle;
				v[2]   = s.halted;
				v[5:4] = s.pkt_cnt;
			end
			default: v = 32'h0000_0000;
		endcase
		return v;
	endfunction : read_reg

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
		logic hit;
		hit = (a[1:0] == 2'h0) && ({{(32-ADDR_W){1'b0}}, a} <= {24'h00_0000, OFS_STATE});
		return hit;
	endfunction : addr_hit

	assign do_wr = s_r.aw_got && s_r.w_got && !s_r.bvalid;

	// bus slave, software writes, then link events; events come last so a set beats a clear
	always_comb begin
		logic [7:0]  b;
		logic [1:0]  depth;
		logic [31:0] wd;
		b     = s_r.wdata[23:16];
		wd    = s_r.wdata;
		depth = s_r.cfg_double ? DEPTH_DOUBLE : DEPTH_SINGLE;
		s_nxt = s_r;
		s_nxt.flush_p     = 1'b0;
		s_nxt.dma_abort_p = 1'b0;

		// write address and data are taken independently
		if (s_r.awready && s_axi_awvalid) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = s_axi_awaddr;
		end
		if (s_r.wready && s_axi_wvalid) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
		end
		if (do_wr) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = addr_hit(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (addr_hit(s_r.awaddr)) begin
				case (s_r.awaddr[7:0])
					OFS_EP_CSR: if (s_r.wstrb[2]) begin
						s_nxt.stall_setup = b[BIT_STALL_SETUP - 16];
						// flags only clear on a written zero; a written one is ignored
						if (!b[BIT_UNDERRUN_ERROR - 16]) s_nxt.flag_undr_err = 1'b0; // see RULE7
						if (!b[BIT_STALL_FLAG - 16]) s_nxt.flag_stall = 1'b0;        // see RULE7
						if (!b[BIT_INCOMP_NAK - 16]) begin
							s_nxt.flag_incp_nak = 1'b0;                                 // see RULE7
							s_nxt.halted        = 1'b0;
						end
						if (b[BIT_CLEAR_TOGGLE - 16]) s_nxt.toggle = 1'b0;         // see RULE4
						// software commits a loaded packet by setting packet-ready
						if (b[BIT_TX_PACKET_READY - 16] && !s_r.tpr && s_r.pkt_cnt < depth) begin
							s_nxt.tpr     = 1'b1;                                     // see RULE15
							s_nxt.pkt_cnt = s_r.pkt_cnt + 2'h1;
							if (host_q && b[BIT_STALL_SETUP - 16]) begin
								s_nxt.setup_tok = 1'b1;                             // see RULE10
								s_nxt.toggle    = 1'b0;                             // see RULE10
							end
						end
						if (b[BIT_FLUSH - 16]) begin
							if (s_nxt.pkt_cnt != 2'h0) s_nxt.pkt_cnt = s_nxt.pkt_cnt - 2'h1; // see RULE11
							s_nxt.tpr                = 1'b0;                          // see RULE11
							s_nxt.setup_tok          = 1'b0;
							s_nxt.flush_p            = 1'b1;
							s_nxt.irq_sts[IRQ_FLUSH] = 1'b1;                         // see RULE11
						end
					end
					OFS_IRQ_STS: if (s_r.wstrb[0]) s_nxt.irq_sts = s_r.irq_sts & ~wd[IRQ_W-1:0];
					OFS_IRQ_MASK: if (s_r.wstrb[0]) s_nxt.irq_mask = wd[IRQ_W-1:0];
					OFS_CFG: begin
						if (s_r.wstrb[0]) begin
							s_nxt.cfg_iso    = wd[CFG_ISO];
							s_nxt.cfg_double = wd[CFG_DOUBLE];
						end
						if (s_r.wstrb[1]) s_nxt.nak_limit = wd[CFG_NAK_LSB +: NAK_W];
					end
					default: s_nxt.bresp = s_nxt.bresp;
				endcase
			end
		end

		// read channel answers one cycle after the address is taken
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
		end
		if (s_r.arready && s_axi_arvalid) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rdata  = read_reg(s_r, host_q, s_axi_araddr);
			s_nxt.rresp  = addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end

		// double buffer frees packet-ready while the second buffer is still empty
		if (s_r.cfg_double && s_r.tpr && s_r.pkt_cnt < DEPTH_DOUBLE) begin
			s_nxt.tpr = 1'b0;                                                   // see RULE16
		end

		// packet done: release buffer, advance toggle unless iso, restart retry counting
		if (pkt_sent) begin
			if (s_nxt.pkt_cnt != 2'h0) s_nxt.pkt_cnt = s_nxt.pkt_cnt - 2'h1;
			s_nxt.tpr                  = 1'b0;                                   // see RULE15
			s_nxt.setup_tok            = 1'b0;
			s_nxt.toggle               = s_r.cfg_iso ? s_nxt.toggle : ~s_nxt.toggle;
			s_nxt.nak_cnt              = '0;
			s_nxt.retry_cnt            = 2'h0;
			s_nxt.irq_sts[IRQ_TX_DONE] = 1'b1;
		end

		if (!host_q) begin
			// underrun means nothing committed; with double buffering the ready bit alone lies
			if (in_token && s_r.pkt_cnt == 2'h0) begin
				s_nxt.flag_undr_err         = 1'b1;                              // see RULE12
				s_nxt.irq_sts[IRQ_UNDR_ERR] = 1'b1;
			end
			if (stall_sent_evt) begin
				s_nxt.flag_stall         = 1'b1;                                  // see RULE5
				s_nxt.pkt_cnt            = 2'h0;                                  // see RULE5
				s_nxt.tpr                = 1'b0;                                  // see RULE5
				s_nxt.flush_p            = 1'b1;
				s_nxt.irq_sts[IRQ_STALL] = 1'b1;
			end
			if (iso_split_short && s_r.cfg_iso) begin
				s_nxt.flag_incp_nak         = 1'b1;                              // see RULE1
				s_nxt.irq_sts[IRQ_INCP_NAK] = 1'b1;
			end
		end else begin
			if (stall_rcvd_evt) begin
				s_nxt.flag_stall         = 1'b1;                                  // see RULE6
				s_nxt.dma_abort_p        = 1'b1;                                  // see RULE6
				s_nxt.pkt_cnt            = 2'h0;                                  // see RULE6
				s_nxt.tpr                = 1'b0;                                  // see RULE6
				s_nxt.setup_tok          = 1'b0;
				s_nxt.flush_p            = 1'b1;
				s_nxt.irq_sts[IRQ_STALL] = 1'b1;
			end
			// a limit of zero leaves the time-out off
			if (nak_rcvd && !pkt_sent) begin
				if (s_r.nak_limit != '0 && s_r.nak_cnt >= s_r.nak_limit) begin
					s_nxt.flag_incp_nak         = 1'b1;                          // see RULE3
					s_nxt.halted                = 1'b1;                          // see RULE3
					s_nxt.nak_cnt               = '0;
					s_nxt.irq_sts[IRQ_INCP_NAK] = 1'b1;
				end else if (s_r.nak_cnt != '1) begin
					s_nxt.nak_cnt = s_r.nak_cnt + NAK_W'(1);
				end
			end
			if (no_handshake && !pkt_sent) begin
				if (s_r.retry_cnt + 2'h1 == RETRY_LIMIT) begin
					s_nxt.flag_undr_err         = 1'b1;                          // see RULE13
					s_nxt.retry_cnt             = 2'h0;
					s_nxt.irq_sts[IRQ_UNDR_ERR] = 1'b1;
				end else begin
					s_nxt.retry_cnt = s_r.retry_cnt + 2'h1;
				end
			end
		end

		// registered outputs, all derived from next state
		s_nxt.awready    = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready     = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.arready    = !s_nxt.rvalid;
		s_nxt.send_stall = !host_q && s_nxt.stall_setup && !s_nxt.cfg_iso;      // see RULE8 RULE9
		s_nxt.pending    = (s_nxt.pkt_cnt != 2'h0) && !s_nxt.halted;
		s_nxt.irq        = |(s_nxt.irq_sts & s_nxt.irq_mask);
	end

	// single state register; reset gives idle bus and quiet endpoint
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r           <= '0;
			s_r.irq_mask  <= RST_IRQ_MASK;
			s_r.nak_limit <= RST_NAK_LIMIT;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign s_axi_awready   = s_r.awready;
	assign s_axi_wready    = s_r.wready;
	assign s_axi_bvalid    = s_r.bvalid;
	assign s_axi_bresp     = s_r.bresp;
	assign s_axi_arready   = s_r.arready;
	assign s_axi_rvalid    = s_r.rvalid;
	assign s_axi_rresp     = s_r.rresp;
	assign s_axi_rdata     = s_r.rdata;
	assign tx_pkt_pending  = s_r.pending;
	assign send_stall_out  = s_r.send_stall;
	assign setup_token_out = s_r.setup_tok;
	assign data_toggle     = s_r.toggle;
	assign ep_halted       = s_r.halted;
	assign fifo_flush      = s_r.flush_p;
	assign dma_abort       = s_r.dma_abort_p;
	assign irq             = s_r.irq;

	// checks
	logic csr_wr;
	assign csr_wr = do_wr && s_r.awaddr[7:0] == OFS_EP_CSR && s_r.wstrb[2];

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	chk_underrun_set: assert property ( // see RULE12
		!host_q && in_token && s_r.pkt_cnt == 2'h0 |=> s_r.flag_undr_err && s_r.irq_sts[IRQ_UNDR_ERR])
		else $error("underrun flag not set");
	chk_incomp_reads_zero: assert property ( // see RULE2
		s_axi_arvalid && s_r.arready && s_axi_araddr[7:0] == OFS_EP_CSR && !host_q && !s_r.cfg_iso
		|=> !s_r.rdata[BIT_INCOMP_NAK])
		else $error("incomplete flag visible on non-iso endpoint");
	chk_stall_sent_flush: assert property ( // see RULE5
		!host_q && stall_sent_evt |=> s_r.flag_stall && !s_r.tpr && s_r.pkt_cnt == 2'h0 && fifo_flush)
		else $error("stall sent without flush");
	chk_stall_rx_abort: assert property ( // see RULE6
		host_q && stall_rcvd_evt |=> s_r.flag_stall && dma_abort && s_r.pkt_cnt == 2'h0 && !s_r.tpr)
		else $error("received stall not handled");
	chk_iso_no_stall: assert property ( // see RULE9
		s_r.cfg_iso ##1 s_r.cfg_iso |-> !send_stall_out)
		else $error("stall issued on iso endpoint");
	chk_stall_follows: assert property ( // see RULE8
		(!host_q && !s_r.cfg_iso && s_r.stall_setup)[*2] |-> send_stall_out)
		else $error("send stall not driven");
	chk_toggle_clear: assert property ( // see RULE4
		csr_wr && s_r.wdata[BIT_CLEAR_TOGGLE] && !pkt_sent |=> !data_toggle)
		else $error("toggle not cleared");
	chk_flush_irq: assert property ( // see RULE11
		csr_wr && s_r.wdata[BIT_FLUSH] |=> fifo_flush && s_r.irq_sts[IRQ_FLUSH] && !s_r.tpr)
		else $error("flush did not complete");
	chk_nak_halt: assert property ( // see RULE3
		host_q && nak_rcvd && !pkt_sent && s_r.nak_limit != '0 && s_r.nak_cnt >= s_r.nak_limit
		|=> s_r.flag_incp_nak ##1 ep_halted)
		else $error("nak time-out missed");
	chk_three_tries: assert property ( // see RULE13
		host_q && no_handshake && !pkt_sent && s_r.retry_cnt == 2'h2 |=> s_r.flag_undr_err)
		else $error("handshake failure not flagged");
	chk_flag_sticky: assert property ( // see RULE7
		s_r.flag_stall && !csr_wr |=> s_r.flag_stall)
		else $error("stall flag dropped without write");
	chk_ready_done: assert property ( // see RULE15
		pkt_sent && !do_wr |=> !s_r.tpr)
		else $error("packet ready not cleared");

	cov_stall_sent: cover property (!host_q && stall_sent_evt);
	cov_setup_sent: cover property (s_r.setup_tok ##[1:50] pkt_sent);
	cov_double_full: cover property (s_r.pkt_cnt == DEPTH_DOUBLE);
	cov_irq_raised: cover property ($rose(irq));
endmodule : utx_ep_ctrl

// File: hdl/utx_pkg.sv
// constants and register layout of the transmit endpoint control/status block
// Notes on behaviour
// RULE1 - device role, iso high-bandwidth: too few IN tokens for all parts sets incomplete flag
// RULE2 - incomplete flag reads zero for any non-isochronous transfer type
// RULE3 - host role: NAKs beyond the NAK limit halt the endpoint and set NAK time-out
// RULE4 - writing one to clear-toggle zeroes the data toggle; zero leaves it
// RULE5 - device role: STALL sent sets stall-sent, flushes FIFO, clears packet-ready
// RULE6 - host role: STALL received sets flag, stops DMA, flushes FIFO, clears packet-ready
// RULE7 - status flags stay set until software writes zero to them
// RULE8 - device role: send-stall set answers IN tokens with STALL; zero ends it
// RULE9 - send-stall has no effect on an isochronous endpoint
// RULE10 - host role: setup bit with packet-ready sends SETUP token and clears toggle
// RULE11 - flush write drops latest packet, clears packet-ready, raises an interrupt
// RULE12 - device role: IN token with no packet ready sets underrun flag
// RULE13 - host role: three attempts without handshake set handshake-failure flag
// RULE14 - FIFO-not-empty reads one while at least one packet is held
// RULE15 - software sets packet-ready after loading; cleared once the packet is sent
// RULE16 - double-buffered: packet-ready clears before the second packet is loaded
// RULE17 - bits 23, 21, 20, 18 take device or host meaning from the current role
package utx_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_EP_CSR   = 8'h00;
	localparam logic [7:0] OFS_IRQ_STS  = 8'h04;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h08;
	localparam logic [7:0] OFS_CFG      = 8'h0C;
	localparam logic [7:0] OFS_STATE    = 8'h10;
	// endpoint_tx_control_status field positions
	localparam int BIT_TX_PACKET_READY = 16;
	localparam int BIT_FIFO_NOT_EMPTY  = 17;
	localparam int BIT_UNDERRUN_ERROR  = 18;
	localparam int BIT_FLUSH           = 19;
	localparam int BIT_STALL_SETUP     = 20;
	localparam int BIT_STALL_FLAG      = 21;
	localparam int BIT_CLEAR_TOGGLE    = 22;
	localparam int BIT_INCOMP_NAK      = 23;
	// interrupt status / mask bit positions
	localparam int IRQ_FLUSH    = 0;
	localparam int IRQ_TX_DONE  = 1;
	localparam int IRQ_STALL    = 2;
	localparam int IRQ_UNDR_ERR = 3;
	localparam int IRQ_INCP_NAK = 4;
	localparam int IRQ_W        = 5;
	// configuration field positions
	localparam int CFG_ISO      = 0;
	localparam int CFG_DOUBLE   = 1;
	localparam int CFG_NAK_LSB  = 8;
	localparam int NAK_W        = 8;
	// reset values
	localparam logic [IRQ_W-1:0] RST_IRQ_MASK  = 5'h00;
	localparam logic [NAK_W-1:0] RST_NAK_LIMIT = 8'h00;
	// counts
	localparam logic [1:0] RETRY_LIMIT = 2'h3;
	localparam logic [1:0] DEPTH_SINGLE = 2'h1;
	localparam logic [1:0] DEPTH_DOUBLE = 2'h2;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : utx_pkg

// File: hdl/utx_sync3.sv
// three-flop synchroniser with agreement filter for a pin level
`timescale 1ns/1ps
module utx_sync3 (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic pin_in,
	output logic      level_q
);
	typedef struct packed {
		logic [2:0] sh;
		logic       q;
	} utx_sync_type;

	utx_sync_type s_r, s_nxt;

	// the first stage feeds only the second; the filter looks at stages two and three
	always_comb begin
		s_nxt    = s_r;
		s_nxt.sh = {s_r.sh[1:0], pin_in};
		if (s_r.sh[1] == s_r.sh[2]) begin
			s_nxt.q = s_r.sh[2];
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level_q = s_r.q;
endmodule : utx_sync3

// File: dv/utx_link_model.sv
// bus partner model: drives link event pulses and watches flush and abort strobes
`timescale 1ns/1ps
module utx_link_model (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic send_stall_out,
	input  wire logic fifo_flush,
	input  wire logic dma_abort,
	output logic      in_token,
	output logic      pkt_sent,
	output logic      stall_sent_evt,
	output logic      stall_rcvd_evt,
	output logic      nak_rcvd,
	output logic      no_handshake,
	output logic      iso_split_short
);
	logic [6:0] ev_r    = 7'h00;
	logic       stall_r;
	int         n_flush = 0;
	int         n_abort = 0;
	// event index 2 unused: the stall answer comes from stall_r
	assign {iso_split_short, no_handshake, nak_rcvd, stall_rcvd_evt, pkt_sent, in_token} = {ev_r[6:3], ev_r[1:0]};
	assign stall_sent_evt = stall_r;
	// an IN token met by a stalled endpoint is answered by a STALL handshake
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) stall_r <= 1'b0;
		else stall_r <= in_token && send_stall_out;
	end
	// strobe counts survive reset so the bench can total them over the run
	always @(posedge core_clk) begin
		n_flush <= n_flush + int'(fifo_flush === 1'b1);
		n_abort <= n_abort + int'(dma_abort === 1'b1);
	end
	// one-cycle pulse, then a settling edge
	task fire(input int k);
		@(posedge core_clk);
		ev_r[k] <= 1'b1;
		@(posedge core_clk);
		ev_r <= 7'h00;
		@(posedge core_clk);
	endtask : fire
endmodule : utx_link_model

// File: dv/usb_tx_endpoint_ctrl_status_tb.sv
// self-checking bench for the transmit endpoint control/status block
`timescale 1ns/1ps
module usb_tx_endpoint_ctrl_status_tb;
	import utx_pkg::*;
	typedef struct packed {logic [1:0] op; logic [7:0] a; logic [31:0] d; logic [31:0] m;} utx_row_type;
	localparam logic [1:0] OP_W = 2'h0, OP_R = 2'h1, OP_E = 2'h2, OP_H = 2'h3;
	localparam logic [7:0] AC = OFS_EP_CSR, AS = OFS_IRQ_STS, AM = OFS_IRQ_MASK, AG = OFS_CFG, AT = OFS_STATE;
	localparam logic [31:0] MC = 32'h00FF_0000;
	logic core_clk, rst_b = 1'b0, host_role_pin = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rd_d;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, irq, ep_halted, data_toggle, setup_token_out, send_stall_out;
	logic [1:0] bresp, rresp, rs;
	logic [31:0] rdata;
	logic in_token, pkt_sent, stall_sent_evt, stall_rcvd_evt, nak_rcvd, no_handshake, iso_split_short;
	logic fifo_flush, dma_abort, tx_pkt_pending;
	int n_fail = 0, n_checks = 0, cyc = 0;
	// ordinary cases: software writes, reads with mask, link events, role switch
	utx_row_type rows [$] = '{
		'{OP_R,AC,32'h0,MC}, '{OP_R,AM,32'h0,32'h1F},
		'{OP_W,AC,32'h0001_0000,MC}, '{OP_R,AC,32'h0003_0000,MC},
		'{OP_E,AC,32'h1,MC}, '{OP_R,AC,32'h0,MC}, '{OP_R,AT,32'h2,32'h2},
		'{OP_W,AC,32'h0,MC}, '{OP_R,AT,32'h2,32'h2}, '{OP_W,AC,32'h0040_0000,MC}, '{OP_R,AT,32'h0,32'h2},
		'{OP_E,AC,32'h0,MC}, '{OP_R,AC,32'h0004_0000,MC},
		'{OP_W,AC,32'h0004_0000,MC}, '{OP_R,AC,32'h0004_0000,MC}, '{OP_W,AC,32'h0,MC}, '{OP_R,AC,32'h0,MC},
		'{OP_W,AC,32'h0001_0000,MC}, '{OP_W,AC,32'h0008_0000,MC}, '{OP_R,AC,32'h0,MC}, '{OP_R,AS,32'h1,32'h1},
		'{OP_W,AC,32'h0011_0000,MC}, '{OP_E,AC,32'h0,MC}, '{OP_R,AC,32'h0030_0000,MC},
		'{OP_W,AC,32'h0,MC}, '{OP_R,AC,32'h0,MC}, '{OP_E,AC,32'h0,MC}, '{OP_R,AC,32'h0,32'h0020_0000},
		'{OP_W,AG,32'h1,MC}, '{OP_W,AC,32'h0010_0000,MC}, '{OP_E,AC,32'h0,MC}, '{OP_R,AC,32'h0,32'h0020_0000},
		'{OP_E,AC,32'h6,MC}, '{OP_R,AC,32'h0080_0000,32'h0080_0000},
		'{OP_W,AG,32'h0,MC}, '{OP_E,AC,32'h6,MC}, '{OP_R,AC,32'h0,32'h0080_0000}, '{OP_W,AC,32'h0,MC},
		'{OP_W,AG,32'h2,MC}, '{OP_W,AC,32'h0001_0000,MC}, '{OP_R,AC,32'h0002_0000,MC},
		'{OP_W,AC,32'h0001_0000,MC}, '{OP_R,AC,32'h0003_0000,MC}, '{OP_R,AT,32'h20,32'h30},
		'{OP_W,AC,32'h0008_0000,MC}, '{OP_R,AC,32'h0002_0000,MC},
		'{OP_W,AC,32'h0008_0000,MC}, '{OP_R,AC,32'h0,MC},
		'{OP_W,AG,32'h0200,MC}, '{OP_H,AC,32'h0,MC}, '{OP_R,AT,32'h1,32'h1},
		'{OP_E,AC,32'h4,MC}, '{OP_E,AC,32'h4,MC}, '{OP_R,AC,32'h0,32'h0080_0000},
		'{OP_E,AC,32'h4,MC}, '{OP_R,AC,32'h0080_0000,32'h0080_0000}, '{OP_R,AT,32'h4,32'h4},
		'{OP_W,AC,32'h0,MC}, '{OP_R,AT,32'h0,32'h4},
		'{OP_E,AC,32'h5,MC}, '{OP_E,AC,32'h5,MC}, '{OP_R,AC,32'h0,32'h0004_0000},
		'{OP_E,AC,32'h5,MC}, '{OP_R,AC,32'h0004_0000,32'h0004_0000},
		'{OP_W,AC,32'h0,MC}, '{OP_W,AC,32'h0001_0000,MC}, '{OP_E,AC,32'h3,MC}, '{OP_R,AC,32'h0020_0000,MC},
		'{OP_W,AC,32'h0,MC}, '{OP_W,AC,32'h0001_0000,MC}, '{OP_E,AC,32'h1,MC}, '{OP_R,AT,32'h3,32'h3},
		'{OP_W,AC,32'h0011_0000,MC}, '{OP_R,AT,32'h1,32'h3}
	};
	utx_ep_ctrl dut (.core_clk(core_clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_role_pin(host_role_pin),
		.in_token(in_token), .pkt_sent(pkt_sent), .stall_sent_evt(stall_sent_evt), .stall_rcvd_evt(stall_rcvd_evt),
		.nak_rcvd(nak_rcvd), .no_handshake(no_handshake), .iso_split_short(iso_split_short),
		.tx_pkt_pending(tx_pkt_pending), .send_stall_out(send_stall_out), .setup_token_out(setup_token_out),
		.data_toggle(data_toggle), .ep_halted(ep_halted), .fifo_flush(fifo_flush), .dma_abort(dma_abort), .irq(irq));
	utx_link_model lnk (.core_clk(core_clk), .rst_b(rst_b), .send_stall_out(send_stall_out), .fifo_flush(fifo_flush),
		.dma_abort(dma_abort), .in_token(in_token), .pkt_sent(pkt_sent), .stall_sent_evt(stall_sent_evt),
		.stall_rcvd_evt(stall_rcvd_evt), .nak_rcvd(nak_rcvd), .no_handshake(no_handshake),
		.iso_split_short(iso_split_short));
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// write: aw and w offered together, each dropped once taken, bready held until bvalid
	task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		awaddr  <= a;
		wdata   <= d;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge core_clk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd
	task end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : end_of_test
	// hang guard, well above the few hundred cycles the run needs
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		foreach (rows[i]) begin
			case (rows[i].op)
				OP_W: begin
					wr(rows[i].a, rows[i].d, rs);
					chk({30'h0, rs}, {30'h0, RESP_OKAY});
				end
				OP_R: begin
					rd(rows[i].a, rd_d, rs);
					chk(rd_d & rows[i].m, rows[i].d);
				end
				OP_E: lnk.fire(int'(rows[i].d));
				default: begin
					host_role_pin <= 1'b1;
					repeat (10) @(posedge core_clk);
				end
			endcase
		end
		chk({31'h0, setup_token_out}, 32'h1);
		chk({31'h0, tx_pkt_pending}, 32'h1);
		chk(32'(lnk.n_abort), 32'h1);
		chk(32'(lnk.n_flush), 32'h5);
		// interrupt: raise by flush, mask, unmask, clear
		wr(AS, 32'h1F, rs);
		wr(AM, 32'h01, rs);
		chk({31'h0, irq}, 32'h0);
		wr(AC, 32'h0008_0000, rs);
		@(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		wr(AM, 32'h00, rs);
		@(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		wr(AM, 32'h01, rs);
		@(posedge core_clk);
		chk({31'h0, irq}, 32'h1);
		wr(AS, 32'h01, rs);
		@(posedge core_clk);
		chk({31'h0, irq}, 32'h0);
		// unmapped word answers an error and reads zero
		wr(8'h14, 32'hFFFF_FFFF, rs);
		chk({30'h0, rs}, {30'h0, RESP_SLVERR});
		rd(8'h14, rd_d, rs);
		chk({rd_d[29:0], rs}, {30'h0, RESP_SLVERR});
		// reset in mid-run clears flags, toggle and halt
		rst_b <= 1'b0;
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		rd(AC, rd_d, rs);
		chk(rd_d & MC, 32'h0);
		chk({29'h0, tx_pkt_pending, ep_halted, data_toggle}, 32'h0);
		end_of_test();
	end
endmodule : usb_tx_endpoint_ctrl_status_tb
